//--- rtl/sscdp_core.sv
// sscdp_core.sv: status flags, shift/receive data path and test modes of
// a synchronous serial channel, reached over the cpu special register port
// assumes: shift clock and serial pins come from outside and are synced;
// rd_stb/wr_stb are one-cycle pulses on clk_sys from the cpu
`timescale 1ns/1ns
`include "sscdp_defines.svh"
package sscdp_pkg;
    typedef enum logic [1:0] {SSCDP_IDLE, SSCDP_SHIFT} sscdp_phase_e;
    typedef struct packed {
        sscdp_phase_e phase;
        logic [7:0] shifter;
        logic [7:0] tx_hold;
        logic [3:0] bit_cnt;
        logic [7:0] test_mode;
        logic [1:0] irq_en;
        logic write_collision_flag;
        logic done;
        logic write_collision_flag_seen;
        logic done_seen;
        logic done_buf_read;
        logic wr_pend;
        logic [7:0] rd_data;
        logic sclk_q;
        logic sdo;
        logic [7:0] rx_buf;
    } sscdp_state_s;
endpackage : sscdp_pkg

module sscdp_core
    import sscdp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rd_data,
    input wire logic master_mode,
    input wire logic sclk_pin,
    input wire logic sdi_pin,
    input wire logic sclk_latch,
    input wire logic sdi_latch,
    output logic serial_data_out,
    output logic sclk_out,
    output logic collision_irq,
    output logic done_irq,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [7:0] rx_data
);
    sscdp_state_s s_reg;
    sscdp_state_s s_next;
    logic [1:0] sclk_sync_reg;
    logic [1:0] sdi_sync_reg;
    logic sclk_in;
    logic sdi_in;
    logic sclk_rise;
    logic sclk_fall;
    logic fifo_in_ready;
    logic fifo_push;
    logic [7:0] sample_byte;
    logic wr_tsd;
    logic rd_rbd;
    logic rd_flags;
    logic wr_flags;
    logic busy;

    // two-stage synchronisers for pins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sclk_sync_reg <= 2'h0;
            sdi_sync_reg <= 2'h0;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[0], sclk_pin};
            sdi_sync_reg <= {sdi_sync_reg[0], sdi_pin};
        end
    end

    // input selection: loopback, port latch or pins
    always_comb begin
        sclk_in = s_reg.test_mode[`SSCDP_BIT_PORTIN] ? sclk_latch : sclk_sync_reg[1];
        if (s_reg.test_mode[`SSCDP_BIT_LOOP]) begin
            sdi_in = ~s_reg.sdo;
        end else if (s_reg.test_mode[`SSCDP_BIT_PORTIN]) begin
            sdi_in = sdi_latch;
        end else begin
            sdi_in = sdi_sync_reg[1];
        end
    end

    // access decode and edge detect
    assign sclk_rise = sclk_in && !s_reg.sclk_q;
    assign sclk_fall = !sclk_in && s_reg.sclk_q;
    assign wr_tsd = wr_stb && (addr == `SSCDP_ADDR_TSD);
    assign rd_rbd = rd_stb && (addr == `SSCDP_ADDR_RBD);
    assign rd_flags = rd_stb && (addr == `SSCDP_ADDR_FLAGS);
    assign wr_flags = wr_stb && (addr == `SSCDP_ADDR_FLAGS);
    assign busy = (s_reg.phase == SSCDP_SHIFT);
    // sampled bit placed by bit order
    always_comb begin
        if (s_reg.test_mode[`SSCDP_BIT_LSB]) begin
            sample_byte = {sdi_in, s_reg.shifter[7:1]};
        end else begin
            sample_byte = {s_reg.shifter[6:0], sdi_in};
        end
    end

    // next-state logic
    always_comb begin
        s_next = s_reg;
        s_next.sclk_q = sclk_in;
        fifo_push = 1'b0;
        // transmit write: collision detected at strobe, flag set two cycles after the strobe
        s_next.wr_pend = 1'b0;
        if (wr_tsd) begin
            s_next.tx_hold = wr_data;
            if (busy) begin
                s_next.wr_pend = 1'b1;
            end else begin
                s_next.shifter = wr_data;
                s_next.bit_cnt = 4'h0;
                s_next.sdo = s_reg.test_mode[`SSCDP_BIT_LSB] ? wr_data[0] : wr_data[7];
                if (master_mode) begin
                    s_next.phase = SSCDP_SHIFT;
                end
            end
        end
        // slave mode: first peer clock edge begins shifting
        if (!busy && !master_mode && sclk_rise) begin
            s_next.phase = SSCDP_SHIFT;
        end
        // shifting: sample on rising, drive on falling
        if (busy || (!master_mode && sclk_rise)) begin
            if (sclk_rise) begin
                s_next.shifter = sample_byte;
                s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
                if (s_reg.bit_cnt == `SSCDP_BITS_PER_XFER - 4'h1) begin
                    s_next.phase = SSCDP_IDLE;
                    s_next.bit_cnt = 4'h0; // next frame counts from zero
                    s_next.rx_buf = sample_byte;
                    fifo_push = 1'b1;
                end
            end else if (sclk_fall) begin
                s_next.sdo = s_reg.test_mode[`SSCDP_BIT_LSB] ? s_reg.shifter[0]
                                                              : s_reg.shifter[7];
            end
        end
        // collision flag and its clears
        if (wr_tsd && s_reg.write_collision_flag_seen) begin
            s_next.write_collision_flag = 1'b0;
            s_next.write_collision_flag_seen = 1'b0;
        end
        if (wr_flags && !wr_data[`SSCDP_BIT_WRITE_COLLISION_FLAG]) begin
            s_next.write_collision_flag = 1'b0;
        end
        if (rd_flags) begin
            s_next.write_collision_flag_seen = s_reg.write_collision_flag;
            s_next.done_seen = s_reg.done;
        end
        if (s_reg.wr_pend) begin
            s_next.write_collision_flag = 1'b1;
        end
        // done flag and its clears
        if (rd_rbd) begin
            s_next.done_buf_read = 1'b1;
            if (s_reg.done_seen) begin
                s_next.done = 1'b0;
                s_next.done_seen = 1'b0;
            end
        end
        if (wr_flags && !wr_data[`SSCDP_BIT_DONE] && s_reg.done_buf_read) begin
            s_next.done = 1'b0;
        end
        if (fifo_push) begin
            s_next.done = 1'b1;
            s_next.done_buf_read = 1'b0;
        end
        // register writes
        if (wr_stb && addr == `SSCDP_ADDR_TMODE) begin
            s_next.test_mode = wr_data & `SSCDP_TMODE_MASK;
        end
        if (wr_stb && addr == `SSCDP_ADDR_IRQEN) begin
            s_next.irq_en = wr_data[1:0];
        end
        // read data mux
        s_next.rd_data = 8'h00;
        if (rd_stb) begin
            unique case (addr)
                `SSCDP_ADDR_TSD: s_next.rd_data = s_reg.tx_hold;
                `SSCDP_ADDR_RBD: s_next.rd_data = s_reg.rx_buf;
                `SSCDP_ADDR_TMODE: s_next.rd_data = s_reg.test_mode;
                `SSCDP_ADDR_FLAGS: s_next.rd_data = {6'h00, s_reg.write_collision_flag, s_reg.done};
                `SSCDP_ADDR_IRQEN: s_next.rd_data = {6'h00, s_reg.irq_en};
                default: s_next.rd_data = 8'h00;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.test_mode <= `SSCDP_TMODE_RESET;
            s_reg.write_collision_flag <= 1'b0;
            s_reg.done <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    // received byte stream: refuses new bytes when full, register view is rx_buf
    sscdp_fifo #(
        .WIDTH(8),
        .DEPTH(`SSCDP_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(sample_byte),
        .out_valid(rx_valid),
        .out_ready(rx_ready || rd_rbd),
        .out_data(rx_data)
    );

    // outputs
    assign rd_data = s_reg.rd_data;
    assign serial_data_out = s_reg.sdo;
    assign sclk_out = sclk_in && busy;
    assign collision_irq = s_reg.write_collision_flag && s_reg.irq_en[1];
    assign done_irq = s_reg.done && s_reg.irq_en[0];

    // assertions
    a_write_collision_flag_sets: assert property (@(posedge clk_sys) disable iff (rst)
        (wr_tsd && busy) |-> ##2 s_reg.write_collision_flag) else $error("collision not flagged");
    a_done_sets: assert property (@(posedge clk_sys) disable iff (rst)
        fifo_push |=> s_reg.done) else $error("done not flagged");
    a_coll_irq: assert property (@(posedge clk_sys) disable iff (rst)
        (s_reg.write_collision_flag && s_reg.irq_en[1]) |-> collision_irq) else $error("no collision irq");
    a_done_gate: assert property (@(posedge clk_sys) disable iff (rst)
        !s_reg.irq_en[0] |-> !done_irq) else $error("done irq not gated");
    a_tx_hold: assert property (@(posedge clk_sys) disable iff (rst)
        wr_tsd |=> s_reg.tx_hold == $past(wr_data)) else $error("tx value lost");
    a_slave_nostart: assert property (@(posedge clk_sys) disable iff (rst)
        (wr_tsd && !busy && !master_mode && !sclk_rise) |=> !busy) else $error("slave start");
    a_tmode_zero: assert property (@(posedge clk_sys) disable iff (rst)
        (s_reg.test_mode[5:1] == 5'h00)) else $error("test bits set");
    a_write_collision_flag_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (wr_flags && !wr_data[1] && !s_reg.wr_pend) |=> !s_reg.write_collision_flag) else $error("write_collision_flag stuck");

    // second clearing paths: flag read armed, then the matching access
    sequence s_write_collision_flag_access;
        wr_tsd && s_reg.write_collision_flag_seen && !busy && !s_reg.wr_pend;
    endsequence
    sequence s_done_access;
        rd_rbd && s_reg.done_seen && !fifo_push;
    endsequence
    a_write_collision_flag_rdclr: assert property (@(posedge clk_sys) disable iff (rst)
        s_write_collision_flag_access |=> !s_reg.write_collision_flag) else $error("write_collision_flag not cleared");
    a_done_rdclr: assert property (@(posedge clk_sys) disable iff (rst)
        s_done_access |=> !s_reg.done) else $error("done not cleared");
    // interrupt requests follow flag and enable
    a_done_irq: assert property (@(posedge clk_sys) disable iff (rst)
        (s_reg.done && s_reg.irq_en[0]) |-> done_irq) else $error("no done irq");
    a_coll_gate: assert property (@(posedge clk_sys) disable iff (rst)
        !s_reg.irq_en[1] |-> !collision_irq) else $error("coll irq not gated");
    // data path: buffer, counter, loopback and first bit
    a_rx_buf: assert property (@(posedge clk_sys) disable iff (rst)
        fifo_push |=> s_reg.rx_buf == $past(sample_byte)) else $error("buffer stale");
    a_bit_range: assert property (@(posedge clk_sys) disable iff (rst)
        s_reg.bit_cnt <= 4'h7) else $error("bit count overrun");
    a_loop_in: assert property (@(posedge clk_sys) disable iff (rst)
        s_reg.test_mode[7] |-> sdi_in == ~s_reg.sdo) else $error("loopback path");
    a_msb_load: assert property (@(posedge clk_sys) disable iff (rst)
        (wr_tsd && !busy && !s_reg.test_mode[0]) |=> s_reg.sdo == $past(wr_data[7]))
        else $error("first bit wrong");
    a_sclk_quiet: assert property (@(posedge clk_sys) disable iff (rst)
        !busy |-> !sclk_out) else $error("clock while idle");
endmodule : sscdp_core

//--- rtl/sscdp_defines.svh
// sscdp_defines.svh: register addresses, field positions and reset values
// assumes: included by bare name from the serial status/data path files
`ifndef SSCDP_DEFINES_SVH
`define SSCDP_DEFINES_SVH
`define SSCDP_ADDR_TSD 8'h94
`define SSCDP_ADDR_RBD 8'h95
`define SSCDP_ADDR_TMODE 8'h96
`define SSCDP_ADDR_FLAGS 8'hAB
`define SSCDP_ADDR_IRQEN 8'hAC
`define SSCDP_BIT_LOOP 7
`define SSCDP_BIT_PORTIN 6
`define SSCDP_BIT_LSB 0
`define SSCDP_BIT_WRITE_COLLISION_FLAG 1
`define SSCDP_BIT_DONE 0
`define SSCDP_TMODE_MASK 8'hC1
`define SSCDP_TMODE_RESET 8'h00
`define SSCDP_FLAGS_RESET 2'h0
`define SSCDP_BITS_PER_XFER 4'h8
`define SSCDP_FIFO_DEPTH 8
`endif

//--- rtl/sscdp_fifo.sv
// sscdp_fifo.sv: small synchronous fifo with valid/ready on both sides
// assumes: one clock, synchronous active-high reset
`timescale 1ns/1ns
module sscdp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;

    // handshakes from occupancy
    assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_reg];

    // pointers, count and storage
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                mem[wr_reg] <= in_data;
                wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : sscdp_fifo

//--- tb/sscdp_peer.sv
// sscdp_peer.sv: external serial master that clocks bytes into the channel
// assumes: 125 ns link clock, low between frames, data sampled on its rise
`timescale 1ns/1ns
module sscdp_peer (
    output logic sclk,
    output logic sdi
);
    // link clock stands still and data shows the inverse when idle
    initial begin
        sclk = 1'b0;
        sdi = 1'b1;
    end
    // one eight-bit frame, wire order chosen by lsb_first
    task automatic send(input logic [7:0] d, input logic lsb_first);
        int i;
        for (i = 0; i < 8; i++) begin
            sdi = lsb_first ? d[i] : d[7-i];
            #62;
            sclk = 1'b1;
            #63;
            sclk = 1'b0;
        end
        sdi = ~sdi;
    endtask : send
endmodule : sscdp_peer

//--- tb/test_sync_serial_status_data_path.sv
// test_sync_serial_status_data_path.sv: self-checking bench for sscdp_core
// assumes: design files and sscdp_peer compiled first
`timescale 1ns/1ns
`include "sscdp_defines.svh"
module test_sync_serial_status_data_path;
    logic clk_sys, rst, wr_stb, rd_stb, master_mode, rx_ready, use_latch;
    logic rd_pend, chk_rx, p_sclk, p_sdi, sclk_pin, sdi_pin, sclk_latch, sdi_latch;
    logic serial_data_out, sclk_out, collision_irq, done_irq, rx_valid;
    logic [7:0] addr, wr_data, rd_data, rx_data, b;
    logic [15:0] q;
    logic [15:0] rd_q[$];
    logic [7:0] rx_q[$];
    int n_fail, cmp_count, seed, k;

    // peer reaches pins or port latches; unused latches and sclk pin stay low, unused sdi pin toggles
    assign sclk_pin = use_latch ? 1'b0 : p_sclk;
    assign sdi_pin = use_latch ? clk_sys : p_sdi;
    assign sclk_latch = use_latch & p_sclk;
    assign sdi_latch = use_latch & p_sdi;

    sscdp_core dut_u (.clk_sys, .rst, .addr, .wr_data, .wr_stb, .rd_stb, .rd_data,
        .master_mode, .sclk_pin, .sdi_pin, .sclk_latch, .sdi_latch, .serial_data_out,
        .sclk_out, .collision_irq, .done_irq, .rx_valid, .rx_ready, .rx_data);
    sscdp_peer peer_u (.sclk(p_sclk), .sdi(p_sdi));

    // system clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic end_sim;
        if (n_fail == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [7:0] got, input logic [7:0] e, input logic [7:0] m);
        cmp_count++;
        if ((got & m) !== e) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, e);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        addr = a;
        wr_data = d;
        wr_stb = 1'b1;
        @(posedge clk_sys);
        #1;
        wr_stb = 1'b0;
    endtask : wr

    // read request; expected value and mask noted for the watcher
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk_sys);
        #1;
        addr = a;
        rd_stb = 1'b1;
        rd_q.push_back({m, e});
        @(posedge clk_sys);
        #1;
        rd_stb = 1'b0;
    endtask : rd

    task automatic rx(input logic [7:0] d, input logic l);
        peer_u.send(d, l);
        repeat (10) @(posedge clk_sys);
        #1;
    endtask : rx

    task automatic irq(input logic [1:0] e);
        repeat (2) @(posedge clk_sys);
        #1;
        chk({6'h00, collision_irq, done_irq}, {6'h00, e}, 8'h03);
        chk({7'h00, sclk_out}, 8'h00, 8'h01);
    endtask : irq

    // watchers: fifo handshakes and read answers one cycle after the strobe
    always @(posedge clk_sys) begin
        rd_pend <= rd_stb;
        if (chk_rx && rx_valid === 1'b1 && rx_ready === 1'b1) begin
            chk(rx_data, rx_q.pop_front(), 8'hFF);
        end
    end
    always @(negedge clk_sys) begin
        if (rd_pend === 1'b1) begin
            q = rd_q.pop_front();
            chk(rd_data, q[7:0], q[15:8]);
        end
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge clk_sys);
        n_fail++;
        end_sim();
    end

    // main sequence
    initial begin
        seed = 88018;
        {n_fail, cmp_count} = 0;
        {rst, wr_stb, rd_stb, master_mode, rx_ready, use_latch, chk_rx, rd_pend} = 8'h80;
        addr = 8'h00;
        wr_data = 8'h00;
        repeat (20) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        rd(`SSCDP_ADDR_TMODE, 8'hFF, 8'h00);
        rd(`SSCDP_ADDR_FLAGS, 8'h03, 8'h00);
        wr(`SSCDP_ADDR_TSD, 8'h11);
        wr(`SSCDP_ADDR_TSD, 8'h22);
        rd(`SSCDP_ADDR_FLAGS, 8'h03, 8'h00);
        rd(`SSCDP_ADDR_TSD, 8'hFF, 8'h22);
        wr(`SSCDP_ADDR_IRQEN, 8'h01);
        // both bit orders; flag read then buffer read clears done
        for (k = 0; k < 2; k++) begin
            wr(`SSCDP_ADDR_TMODE, {7'h00, k[0]});
            b = 8'($random(seed));
            rx(b, k[0]);
            irq(2'b01);
            rd(`SSCDP_ADDR_FLAGS, 8'h03, 8'h01);
            rd(`SSCDP_ADDR_RBD, 8'hFF, b);
            rd(`SSCDP_ADDR_FLAGS, 8'h03, 8'h00);
        end
        // unread byte overwritten; enables off gate the request
        wr(`SSCDP_ADDR_IRQEN, 8'h00);
        wr(`SSCDP_ADDR_TMODE, 8'h00);
        rx(8'h3C, 1'b0);
        rx(8'hA6, 1'b0);
        irq(2'b00);
        rd(`SSCDP_ADDR_RBD, 8'hFF, 8'hA6);
        wr(`SSCDP_ADDR_FLAGS, 8'h00);
        rd(`SSCDP_ADDR_FLAGS, 8'h03, 8'h00);
        // master mode collisions and both clearing paths
        wr(`SSCDP_ADDR_IRQEN, 8'h02);
        master_mode = 1'b1;
        wr(`SSCDP_ADDR_TSD, 8'h5A);
        chk({7'h00, serial_data_out}, 8'h00, 8'h01);
        wr(`SSCDP_ADDR_TSD, 8'hC3);
        irq(2'b10);
        rd(`SSCDP_ADDR_FLAGS, 8'h03, 8'h02);
        rd(`SSCDP_ADDR_TSD, 8'hFF, 8'hC3);
        wr(`SSCDP_ADDR_FLAGS, 8'h00);
        rd(`SSCDP_ADDR_FLAGS, 8'h03, 8'h00);
        wr(`SSCDP_ADDR_TSD, 8'h96);
        rd(`SSCDP_ADDR_FLAGS, 8'h03, 8'h02);
        rx(8'h81, 1'b0);
        wr(`SSCDP_ADDR_TSD, 8'h00);
        rd(`SSCDP_ADDR_FLAGS, 8'h03, 8'h01);
        wr(`SSCDP_ADDR_IRQEN, 8'h00);
        irq(2'b00);
        rd(`SSCDP_ADDR_RBD, 8'hFF, 8'h81);
        rx(8'h00, 1'b0);
        // loopback returns the inverted transmit byte
        wr(`SSCDP_ADDR_TMODE, 8'h80);
        b = 8'($random(seed));
        wr(`SSCDP_ADDR_TSD, b);
        rx(8'h00, 1'b0);
        rd(`SSCDP_ADDR_RBD, 8'hFF, ~b);
        // slave transfer emulated through the port latches
        master_mode = 1'b0;
        wr(`SSCDP_ADDR_TMODE, 8'h40);
        use_latch = 1'b1;
        rx(8'h6D, 1'b0);
        rd(`SSCDP_ADDR_RBD, 8'hFF, 8'h6D);
        use_latch = 1'b0;
        wr(`SSCDP_ADDR_TMODE, 8'h00);
        // empty fifo, fill all eight words stalled, then drain unevenly
        rx_ready = 1'b1;
        repeat (20) @(posedge clk_sys);
        #1;
        rx_ready = 1'b0;
        chk_rx = 1'b1;
        for (k = 0; k < 8; k++) begin
            b = 8'($random(seed));
            rx_q.push_back(b);
            rx(b, 1'b0);
        end
        repeat (60) begin
            @(posedge clk_sys);
            #1;
            b = 8'($random(seed));
            rx_ready = b[0];
        end
        chk(8'(rx_q.size()), 8'h00, 8'hFF);
        end_sim();
    end
endmodule : test_sync_serial_status_data_path
